// [rtl/mspc_defines.vh]
// Constants for the modem serial port control block.
// Included by the design file; holds definitions only.
`ifndef MSPC_DEFINES_VH
`define MSPC_DEFINES_VH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define MSPC_REG_CTRL 8'h00
`define MSPC_REG_FRAME 8'h04
`define MSPC_REG_POWERUP 8'h08
`define MSPC_REG_STATUS 8'h0c
`define MSPC_REG_CMDCHAR 8'h10
`define MSPC_REG_CIRCUIT 8'h14

// ---------------------------------------------------------------
// Control fields
// ---------------------------------------------------------------
`define MSPC_CTRL_SHORT_OBRK 0
`define MSPC_CTRL_SHORT_IBRK 1
`define MSPC_CTRL_XTRASTOP 2
`define MSPC_CTRL_LAMP_MODE 3
`define MSPC_CTRL_CONSERVE 4
`define MSPC_CTRL_SEND_BRK 5
`define MSPC_CTRL_DEFAULT 6
`define MSPC_CTRL_INITIAL 7
`define MSPC_CTRL_COMM 8

// ---------------------------------------------------------------
// Framing: rate code [3:0], parity [6:4], 8 data [7], 2 stop [8]
// ---------------------------------------------------------------
`define MSPC_PAR_N 3'h0
`define MSPC_PAR_S 3'h1
`define MSPC_PAR_M 3'h2
`define MSPC_PAR_E 3'h3
`define MSPC_PAR_O 3'h4
`define MSPC_RATE_600 4'h2
`define MSPC_RATE_9600 4'h6
`define MSPC_FRAME_DEFAULT 9'h086

// ---------------------------------------------------------------
// Limits and times
// ---------------------------------------------------------------
`define MSPC_MAX_PACKET 128
`define MSPC_MAX_CMD_LEN 191
`define MSPC_CLK_MHZ 200
`define MSPC_MS_CYCLES (`MSPC_CLK_MHZ * 1000)
`define MSPC_OBRK_LONG_MS 245
`define MSPC_OIDLE_LONG_MS 100
`define MSPC_OBRK_SHORT_MAX_MS 215
`define MSPC_OBRK_SHORT_MIN_MS 35
`define MSPC_OIDLE_SHORT_MS 20
`define MSPC_IBRK_LONG_MS 210
`define MSPC_IBRK_EXTRA_MS 20

// ---------------------------------------------------------------
// Characters
// ---------------------------------------------------------------
`define MSPC_CH_CR 8'h0d
`define MSPC_CH_LF 8'h0a
`define MSPC_CH_TAB 8'h09
`define MSPC_CH_SP 8'h20
`define MSPC_CH_BEL 8'h07
`define MSPC_CH_CAN 8'h18
`define MSPC_CH_DEL 8'h7f
`define MSPC_CH_BS 8'h08
`define MSPC_CH_PLUS 8'h2b

`endif

// [rtl/mspc_serial_port_ctrl.v]
// Serial port control for a packet radio modem terminal port.
// Assumes one 200 MHz clock, AXI4-Lite master, async line inputs.
`timescale 1ns/1ps
`include "mspc_defines.vh"

// What this block does
// - Packets carry at most 128 data bytes
// - Assert flow control near buffer full
// - Command lines limited to 191 characters
// - Space, tab, line-feed are insignificant
// - Echo accepted characters, BEL for rejected ones
// - Backspace after error drops back past error
// - Bare circuit command reports current value
// - Framing command: letter, rate, parity, bits
// - New rate applies after CR response
// - Initial restores stored power-up framing
// - Short output break 215..35 ms, 20 idle
// - Default output break 245 ms, 100 idle
// - Short input break: 20ms and a char time (10-bit chars: char time)
// - Otherwise breaks need 210 ms, else NUL
// - Extra stop bit at 600 or below
// - Power-on circuit 01, bare communicate uses it
// - Other circuit discards and blocks data
// - Default loads 9600 N 8 1, keeps power-up
// - Lamp mode 0 blinks while queues busy
// - Lamp mode 1 follows transmitter keying
// - Terminator acts as CR, controls echo BEL
// - Control-X or DEL cancels partial command
module mspc_serial_port_ctrl #(
  parameter MS_CYCLES = `MSPC_MS_CYCLES,
  parameter EDIT_DEPTH = 256,
  parameter FULL_MARGIN = 20
) (
  input wire clk_i,
  input wire resetn_i,
  input wire clk_en_i,
  // AXI4-Lite
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Terminal characters in (already deserialised) and status
  input wire [7:0] cmd_char_i,
  input wire cmd_char_valid_i,
  input wire cmd_mode_i,
  input wire edit_push_i,
  input wire edit_pop_i,
  input wire link_up_i,
  input wire [9:0] bit_cycles_i,
  // Async line level of terminal transmit data and keying
  input wire txd_line_i,
  input wire tx_key_i,
  input wire queues_busy_i,
  input wire msg_sent_i,
  // Outputs
  output reg [7:0] echo_char_o,
  output reg echo_valid_o,
  output reg line_done_o,
  output reg report_o,
  output reg cancel_o,
  output reg flow_off_o,
  output reg rxd_break_o,
  output reg break_seen_o,
  output reg nul_seen_o,
  output reg [8:0] frame_o,
  output reg extra_stop_o,
  output reg data_mode_o,
  output reg data_pass_o,
  output reg [7:0] pkt_limit_o,
  output reg green_lamp_o,
  output reg conserve_o
);

// ---------------------------------------------------------------
// Helpers
// ---------------------------------------------------------------
function is_blank;
  input [7:0] c;
  begin
    is_blank = (c == `MSPC_CH_SP) || (c == `MSPC_CH_TAB) ||
      (c == `MSPC_CH_LF);
  end
endfunction

localparam [7:0] MAX_LEN = `MSPC_MAX_CMD_LEN;
localparam [8:0] DEPTH = EDIT_DEPTH;
localparam [8:0] MARGIN = FULL_MARGIN;

// ---------------------------------------------------------------
// Input synchroniser and ms tick
// ---------------------------------------------------------------
reg txd_meta;
reg txd_sync;
reg key_meta;
reg key_sync;
reg [17:0] ms_cnt;
wire ms_tick = (ms_cnt == MS_CYCLES - 1);

always @(posedge clk_i)
begin
  if (!resetn_i)
  begin
    txd_meta <= 1'b1;
    txd_sync <= 1'b1;
    key_meta <= 1'b0;
    key_sync <= 1'b0;
    ms_cnt <= 18'h00000;
  end
  else if (clk_en_i)
  begin
    txd_meta <= txd_line_i;
    txd_sync <= txd_meta;
    key_meta <= tx_key_i;
    key_sync <= key_meta;
    ms_cnt <= ms_tick ? 18'h00000 : ms_cnt + 18'h00001;
  end
end

// ---------------------------------------------------------------
// Configuration registers
// ---------------------------------------------------------------
reg short_obrk, short_ibrk, xtrastop, lamp_mode;
reg [8:0] powerup;
reg [7:0] term_char;
reg [7:0] circuit;
reg send_brk_req;
reg [8:0] pending_frame;
reg pending_rate;

wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
wire rd_go = s_axi_arvalid && !s_axi_rvalid;
assign s_axi_awready = wr_go;
assign s_axi_wready = wr_go;
assign s_axi_arready = rd_go;
wire [31:0] wd = s_axi_wdata;
wire [8:0] wframe = wd[8:0];
wire frame_ok = (wd[3:0] != 4'h0) && (wd[6:4] <= `MSPC_PAR_O) &&
  !(wd[6:4] == `MSPC_PAR_N && !wd[7] && !wd[8]) &&
  !(wd[6:4] != `MSPC_PAR_N && wd[7] && wd[8]);
reg err_flag;
reg [8:0] edit_cnt;
reg [1:0] ob_state;
localparam [1:0] OB_IDLE = 2'h0;
wire brk_start = (ob_state == OB_IDLE) && send_brk_req;

always @(posedge clk_i)
begin
  if (!resetn_i)
  begin
    short_obrk <= 1'b0;
    short_ibrk <= 1'b0;
    xtrastop <= 1'b0;
    lamp_mode <= 1'b0;
    conserve_o <= 1'b0;
    powerup <= `MSPC_FRAME_DEFAULT;
    frame_o <= `MSPC_FRAME_DEFAULT;
    term_char <= `MSPC_CH_PLUS;
    circuit <= 8'h01;
    data_mode_o <= 1'b0;
    send_brk_req <= 1'b0;
    pending_frame <= `MSPC_FRAME_DEFAULT;
    pending_rate <= 1'b0;
    report_o <= 1'b0;
    s_axi_bvalid <= 1'b0;
    s_axi_bresp <= 2'b00;
  end
  else if (clk_en_i)
  begin
    report_o <= 1'b0;
    if (s_axi_bvalid && s_axi_bready)
      s_axi_bvalid <= 1'b0;
    if (brk_start)
      send_brk_req <= 1'b0;
    // New rate waits for end of response line
    if (pending_rate && line_done_o)
    begin
      frame_o <= pending_frame;
      pending_rate <= 1'b0;
    end
    if (!cmd_mode_i && data_mode_o)
      data_mode_o <= data_mode_o;
    if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= 2'b00;
      case (s_axi_awaddr)
        `MSPC_REG_CTRL:
        begin
          if (s_axi_wstrb[0])
          begin
            short_obrk <= wd[`MSPC_CTRL_SHORT_OBRK];
            short_ibrk <= wd[`MSPC_CTRL_SHORT_IBRK];
            xtrastop <= wd[`MSPC_CTRL_XTRASTOP];
            lamp_mode <= wd[`MSPC_CTRL_LAMP_MODE];
            conserve_o <= wd[`MSPC_CTRL_CONSERVE];
            if (wd[`MSPC_CTRL_SEND_BRK])
              send_brk_req <= 1'b1;
            if (wd[`MSPC_CTRL_DEFAULT])
            begin
              frame_o <= `MSPC_FRAME_DEFAULT;
              short_obrk <= 1'b0;
              short_ibrk <= 1'b0;
              xtrastop <= 1'b0;
              lamp_mode <= 1'b0;
              conserve_o <= 1'b0;
              term_char <= `MSPC_CH_PLUS;
              pending_rate <= 1'b0;
            end
            if (wd[`MSPC_CTRL_INITIAL])
              frame_o <= powerup;
          end
          if (s_axi_wstrb[1])
            data_mode_o <= wd[`MSPC_CTRL_COMM];
        end
        `MSPC_REG_FRAME:
          if (frame_ok)
          begin
            pending_frame <= wframe;
            pending_rate <= 1'b1;
          end
          else
            s_axi_bresp <= 2'b10;
        `MSPC_REG_POWERUP:
          if (frame_ok)
            powerup <= wframe;
          else
            s_axi_bresp <= 2'b10;
        `MSPC_REG_CMDCHAR:
          if (s_axi_wstrb[0])
            term_char <= wd[7:0];
        `MSPC_REG_CIRCUIT:
          if (s_axi_wstrb[0])
          begin
            // A bare write of zero keeps the circuit, reports it
            if (wd[7:0] == 8'h00)
              report_o <= 1'b1;
            else
              circuit <= wd[7:0];
          end
        default:
          s_axi_bresp <= 2'b10;
      endcase
    end
  end
end

// ---------------------------------------------------------------
// Register read
// ---------------------------------------------------------------
always @(posedge clk_i)
begin
  if (!resetn_i)
  begin
    s_axi_rvalid <= 1'b0;
    s_axi_rdata <= 32'h00000000;
    s_axi_rresp <= 2'b00;
  end
  else if (clk_en_i)
  begin
    if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
    if (rd_go)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      case (s_axi_araddr)
        `MSPC_REG_CTRL:
          s_axi_rdata <= {23'h000000, data_mode_o, 3'h0, conserve_o,
            lamp_mode, xtrastop, short_ibrk, short_obrk};
        `MSPC_REG_FRAME:
          s_axi_rdata <= {23'h000000, frame_o};
        `MSPC_REG_POWERUP:
          s_axi_rdata <= {23'h000000, powerup};
        `MSPC_REG_STATUS:
          s_axi_rdata <= {18'h00000, edit_cnt, flow_off_o, err_flag,
            rxd_break_o, pending_rate, data_pass_o};
        `MSPC_REG_CMDCHAR:
          s_axi_rdata <= {24'h000000, term_char};
        `MSPC_REG_CIRCUIT:
          s_axi_rdata <= {24'h000000, circuit};
        default:
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end
  end
end

// ---------------------------------------------------------------
// Command line entry
// ---------------------------------------------------------------
reg [7:0] cmd_len;
reg [7:0] err_pos;
wire is_term = (cmd_char_i == `MSPC_CH_CR) || (cmd_char_i == term_char);
wire is_cancel = (cmd_char_i == `MSPC_CH_CAN) ||
  (cmd_char_i == `MSPC_CH_DEL);
wire is_ctrl = (cmd_char_i < `MSPC_CH_SP);

always @(posedge clk_i)
begin
  if (!resetn_i)
  begin
    cmd_len <= 8'h00;
    err_pos <= 8'h00;
    err_flag <= 1'b0;
    echo_char_o <= 8'h00;
    echo_valid_o <= 1'b0;
    line_done_o <= 1'b0;
    cancel_o <= 1'b0;
  end
  else if (clk_en_i)
  begin
    echo_valid_o <= 1'b0;
    line_done_o <= 1'b0;
    cancel_o <= 1'b0;
    if (cmd_char_valid_i && cmd_mode_i)
    begin
      if (is_term)
      begin
        line_done_o <= 1'b1;
        cmd_len <= 8'h00;
        err_flag <= 1'b0;
      end
      else if (is_cancel)
      begin
        cancel_o <= 1'b1;
        cmd_len <= 8'h00;
        err_flag <= 1'b0;
      end
      else if (cmd_char_i == `MSPC_CH_BS)
      begin
        if (err_flag)
        begin
          cmd_len <= err_pos;
          err_flag <= 1'b0;
        end
        else if (cmd_len != 8'h00)
          cmd_len <= cmd_len - 8'h01;
      end
      else if (is_blank(cmd_char_i))
        cmd_len <= cmd_len;
      else if (is_ctrl)
      begin
        echo_char_o <= `MSPC_CH_BEL;
        echo_valid_o <= 1'b1;
      end
      else if (cmd_len >= MAX_LEN - 8'h01)
      begin
        // Room only for the terminator
        echo_char_o <= `MSPC_CH_BEL;
        echo_valid_o <= 1'b1;
        if (!err_flag)
          err_pos <= cmd_len;
        err_flag <= 1'b1;
      end
      else
      begin
        cmd_len <= cmd_len + 8'h01;
        echo_char_o <= cmd_char_i;
        echo_valid_o <= !err_flag;
      end
    end
  end
end

// ---------------------------------------------------------------
// Edit buffer fill and flow control
// ---------------------------------------------------------------
always @(posedge clk_i)
begin
  if (!resetn_i)
  begin
    edit_cnt <= 9'h000;
    flow_off_o <= 1'b0;
    pkt_limit_o <= 8'h00;
  end
  else if (clk_en_i)
  begin
    if (edit_push_i && !edit_pop_i && edit_cnt != DEPTH)
      edit_cnt <= edit_cnt + 9'h001;
    else if (edit_pop_i && !edit_push_i && edit_cnt != 9'h000)
      edit_cnt <= edit_cnt - 9'h001;
    flow_off_o <= (edit_cnt >= DEPTH - MARGIN) || !link_up_i;
    pkt_limit_o <= (edit_cnt > 9'd128) ? 8'd128 : edit_cnt[7:0];
  end
end

// ---------------------------------------------------------------
// Output break generator
// ---------------------------------------------------------------
reg [7:0] ob_ms;
localparam [1:0] OB_BRK = 2'h1;
localparam [1:0] OB_STOP = 2'h2;
// Short break shrinks 28 ms per rate step, floor 35 ms
wire [7:0] short_ms = (frame_o[3:0] > 4'h6) ?
  8'd35 : 8'd215 - {2'h0, frame_o[3:0], 2'h0} * 8'd7;

always @(posedge clk_i)
begin
  if (!resetn_i)
  begin
    ob_state <= OB_IDLE;
    ob_ms <= 8'h00;
    rxd_break_o <= 1'b0;
  end
  else if (clk_en_i)
  begin
    case (ob_state)
      OB_IDLE:
        if (send_brk_req)
        begin
          ob_state <= OB_BRK;
          rxd_break_o <= 1'b1;
          ob_ms <= short_obrk ? short_ms : 8'd245;
        end
      OB_BRK:
        if (ms_tick)
        begin
          if (ob_ms == 8'h01)
          begin
            ob_state <= OB_STOP;
            rxd_break_o <= 1'b0;
            ob_ms <= short_obrk ? 8'd20 : 8'd100;
          end
          else
            ob_ms <= ob_ms - 8'h01;
        end
      OB_STOP:
        if (ms_tick)
        begin
          if (ob_ms == 8'h01)
            ob_state <= OB_IDLE;
          else
            ob_ms <= ob_ms - 8'h01;
        end
      default:
        ob_state <= OB_IDLE;
    endcase
  end
end

// ---------------------------------------------------------------
// Input break detector
// ---------------------------------------------------------------
reg [7:0] low_ms;
reg [17:0] low_cyc;
reg low_prev;
wire [3:0] bits = 4'd9 + {3'h0, frame_o[7]} + {3'h0, frame_o[8]} +
  {3'h0, frame_o[6:4] != `MSPC_PAR_N};
wire [17:0] char_cyc = bit_cycles_i * bits;
wire [17:0] ten_cyc = bit_cycles_i * 4'd10;
wire short_hit = (low_ms >= `MSPC_IBRK_EXTRA_MS &&
  low_cyc >= char_cyc) || (bits == 4'd10 && low_cyc >= ten_cyc);
wire brk_hit = short_ibrk ? short_hit : (low_ms >= 8'd210);

always @(posedge clk_i)
begin
  if (!resetn_i)
  begin
    low_ms <= 8'h00;
    low_cyc <= 18'h00000;
    low_prev <= 1'b0;
    break_seen_o <= 1'b0;
    nul_seen_o <= 1'b0;
  end
  else if (clk_en_i)
  begin
    break_seen_o <= 1'b0;
    nul_seen_o <= 1'b0;
    if (!txd_sync)
    begin
      if (low_cyc != 18'h3ffff)
        low_cyc <= low_cyc + 18'h00001;
      if (ms_tick && low_ms != 8'hff)
        low_ms <= low_ms + 8'h01;
      low_prev <= 1'b1;
    end
    else
    begin
      if (low_prev && low_cyc >= char_cyc)
      begin
        break_seen_o <= brk_hit;
        nul_seen_o <= !brk_hit;
      end
      low_ms <= 8'h00;
      low_cyc <= 18'h00000;
      low_prev <= 1'b0;
    end
  end
end

// ---------------------------------------------------------------
// Stop bits, circuit gate and lamp
// ---------------------------------------------------------------
reg [7:0] blink_ms;
always @(posedge clk_i)
begin
  if (!resetn_i)
  begin
    extra_stop_o <= 1'b0;
    data_pass_o <= 1'b0;
    green_lamp_o <= 1'b0;
    blink_ms <= 8'h00;
  end
  else if (clk_en_i)
  begin
    extra_stop_o <= xtrastop && frame_o[3:0] <= `MSPC_RATE_600;
    data_pass_o <= data_mode_o && circuit == 8'h01;
    if (lamp_mode)
      green_lamp_o <= key_sync;
    else if (msg_sent_i)
    begin
      green_lamp_o <= 1'b1;
      blink_ms <= 8'd50;
    end
    else if (blink_ms != 8'h00)
    begin
      if (ms_tick)
        blink_ms <= blink_ms - 8'h01;
    end
    else if (queues_busy_i && ms_tick)
      green_lamp_o <= !green_lamp_o;
    else if (!queues_busy_i)
      green_lamp_o <= 1'b0;
  end
end

endmodule // mspc_serial_port_ctrl

// [verif/mspc_checker_assertions.sv]
// Port checks of the serial port control block.
// Bound into the control block; sees only its ports.
`timescale 1ns/1ps
`include "mspc_defines.vh"
module mspc_checker #(
  parameter MS_CYCLES = 200000
) (
  input wire clk_i,
  input wire resetn_i,
  input wire clk_en_i,
  input wire [7:0] cmd_char_i,
  input wire cmd_char_valid_i,
  input wire cmd_mode_i,
  input wire [7:0] echo_char_o,
  input wire echo_valid_o,
  input wire line_done_o,
  input wire cancel_o,
  input wire rxd_break_o,
  input wire [8:0] frame_o,
  input wire data_mode_o,
  input wire data_pass_o,
  input wire [7:0] pkt_limit_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  // ----
  // Run length of the output break level
  // ----
  logic prev;
  logic [31:0] run;
  wire take = cmd_char_valid_i && cmd_mode_i && clk_en_i;
  always @(posedge clk_i)
    if (!resetn_i)
    begin
      prev <= 1'h0;
      run <= 32'hffffffff;
    end
    else
    begin
      prev <= rxd_break_o;
      if (rxd_break_o != prev)
        run <= 32'h1;
      else if (run != 32'hffffffff)
        run <= run + 32'h1;
    end
  sequence brk_end;
    $fell(rxd_break_o);
  endsequence
  sequence brk_start;
    $rose(rxd_break_o);
  endsequence
  cancel_char_a: assert property (
    take && (cmd_char_i == `MSPC_CH_CAN || cmd_char_i == `MSPC_CH_DEL)
    |=> cancel_o) else $error("cancel missing");
  cr_done_a: assert property (
    take && cmd_char_i == `MSPC_CH_CR |=> line_done_o)
    else $error("line end missing");
  bel_echo_a: assert property (
    take && cmd_char_i == 8'h01
    |=> echo_valid_o && echo_char_o == `MSPC_CH_BEL)
    else $error("control char not echoed as bell");
  pkt_limit_a: assert property (
    pkt_limit_o <= 8'h80) else $error("packet limit too big");
  pass_mode_a: assert property (
    data_pass_o |-> data_mode_o) else $error("pass outside data mode");
  reset_frame_a: assert property (
    $rose(resetn_i) |-> frame_o == `MSPC_FRAME_DEFAULT)
    else $error("reset framing wrong");
  break_len_a: assert property (
    brk_end |-> run >= 29 * MS_CYCLES && run <= 251 * MS_CYCLES)
    else $error("break length out of range");
  break_idle_a: assert property (
    brk_start |-> run >= 19 * MS_CYCLES) else $error("idle too short");
endmodule // mspc_checker
bind mspc_serial_port_ctrl mspc_checker #(.MS_CYCLES(MS_CYCLES)) chk_i (
  .clk_i(clk_i),
  .resetn_i(resetn_i),
  .clk_en_i(clk_en_i),
  .cmd_char_i(cmd_char_i),
  .cmd_char_valid_i(cmd_char_valid_i),
  .cmd_mode_i(cmd_mode_i),
  .echo_char_o(echo_char_o),
  .echo_valid_o(echo_valid_o),
  .line_done_o(line_done_o),
  .cancel_o(cancel_o),
  .rxd_break_o(rxd_break_o),
  .frame_o(frame_o),
  .data_mode_o(data_mode_o),
  .data_pass_o(data_pass_o),
  .pkt_limit_o(pkt_limit_o)
);

// [verif/mspc_serial_port_ctrl_bench.sv]
// Self-checking bench of the serial port control block.
// Uses the terminal model and the bound checker.
`timescale 1ns/1ps
`include "mspc_defines.vh"
module mspc_serial_port_ctrl_bench;
  localparam int MS = 10;
  logic clk_i = 1'h0;
  logic resetn_i = 1'h0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic push = 1'h0;
  logic pop = 1'h0;
  logic key = 1'h0;
  logic mode = 1'h1;
  wire awready, wready, bvalid, arready, rvalid, cvalid, txd, evalid;
  wire done, cancel, flow, rbrk, bseen, nseen, xstop, dmode, dpass, lamp;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] cchar, echar, plim;
  wire [8:0] frame;
  int n_mismatch = 0;
  int compares = 0;
  always #2.5 clk_i = ~clk_i;
  mspc_terminal_model mspc_terminal_model_i (.clk_i(clk_i),
    .char_o(cchar), .char_valid_o(cvalid), .txd_line_o(txd));
  mspc_serial_port_ctrl #(.MS_CYCLES(MS)) mspc_serial_port_ctrl_i (
    .clk_i(clk_i), .resetn_i(resetn_i), .clk_en_i(1'h1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cmd_char_i(cchar), .cmd_char_valid_i(cvalid), .cmd_mode_i(mode),
    .edit_push_i(push), .edit_pop_i(pop), .link_up_i(1'h1),
    .bit_cycles_i(10'h014), .txd_line_i(txd), .tx_key_i(key),
    .queues_busy_i(1'h0), .msg_sent_i(1'h0), .echo_char_o(echar),
    .echo_valid_o(evalid), .line_done_o(done), .report_o(),
    .cancel_o(cancel), .flow_off_o(flow), .rxd_break_o(rbrk),
    .break_seen_o(bseen), .nul_seen_o(nseen), .frame_o(frame),
    .extra_stop_o(xstop), .data_mode_o(dmode), .data_pass_o(dpass),
    .pkt_limit_o(plim), .green_lamp_o(lamp), .conserve_o());
  // ----
  // Shared tasks
  // ----
  task chk(input logic [31:0] seen, input logic [31:0] exp,
    input string what);
    begin
      compares++;
      if (seen !== exp)
      begin
        n_mismatch++;
        $display("Error %s: expected %h, seen %h", what, exp, seen);
      end
    end
  endtask
  task end_sim;
    begin
      if (n_mismatch == 0 && compares > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    begin
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do
      begin
        @(posedge clk_i);
        if (awready)
          awvalid <= 1'h0;
        if (wready)
          wvalid <= 1'h0;
      end while (!bvalid);
      bready <= 1'h0;
      chk(bresp, er, "bresp");
      @(posedge clk_i);
      #1;
    end
  endtask
  task rd(input logic [7:0] a, input logic [31:0] ed,
    input logic [1:0] er);
    begin
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do
      begin
        @(posedge clk_i);
        if (arready)
          arvalid <= 1'h0;
      end while (!rvalid);
      rready <= 1'h0;
      chk(rdata, ed, "rdata");
      chk(rresp, er, "rresp");
      @(posedge clk_i);
      #1;
    end
  endtask
  task ctl(input logic [31:0] d);
    wr(`MSPC_REG_CTRL, d, 2'h0);
  endtask
  task edit(input logic up, input int k);
    begin
      push <= up;
      pop <= !up;
      repeat (k) @(posedge clk_i);
      push <= 1'h0;
      pop <= 1'h0;
      repeat (2) @(posedge clk_i);
      #1;
    end
  endtask
  task brk_out(input logic [31:0] c, input int ms);
    int n;
    begin
      ctl(c);
      for (n = 0; rbrk && n < 5000; n++)
        @(posedge clk_i);
      chk(n > (ms - 7) * MS && n < (ms + 7) * MS, 1, "break out");
      repeat (110 * MS) @(posedge clk_i);
    end
  endtask
  task brk_in(input int ms, input logic b);
    int n;
    begin
      mspc_terminal_model_i.hold_low(ms * MS);
      for (n = 0; !bseen && !nseen && n < 50; n++)
        @(posedge clk_i);
      chk(bseen, b, "break in");
      chk(nseen, !b, "nul in");
      @(posedge clk_i);
      #1;
    end
  endtask
  // ----
  // Scenarios
  // ----
  task t_chars;
    logic [7:0] c [6];
    int i;
    begin
      c = '{`MSPC_CH_CR, `MSPC_CH_PLUS, `MSPC_CH_CAN, `MSPC_CH_DEL,
        8'h01, 8'h03};
      for (i = 0; i < 6; i++)
      begin
        mspc_terminal_model_i.send(c[i]);
        chk(done, i < 2, "line end");
        chk(cancel, i inside {2, 3}, "cancel");
        if (i > 3)
          chk({evalid, echar}, {1'h1, `MSPC_CH_BEL}, "echo");
      end
      mspc_terminal_model_i.send(8'h62);
      chk({evalid, echar}, 9'h162, "echo");
      mspc_terminal_model_i.send(`MSPC_CH_SP);
      chk(evalid, 0, "blank");
      for (i = 0; i < 189; i++)
        mspc_terminal_model_i.send(8'h61);
      chk({evalid, echar}, 9'h161, "fill");
      mspc_terminal_model_i.send(8'h61);
      chk({evalid, echar}, {1'h1, `MSPC_CH_BEL}, "limit");
      rd(`MSPC_REG_STATUS, 32'h8, 2'h0);
      mspc_terminal_model_i.send(`MSPC_CH_BS);
      rd(`MSPC_REG_STATUS, 32'h0, 2'h0);
      mode <= 1'h0;
      mspc_terminal_model_i.send(`MSPC_CH_CR);
      chk(done, 0, "line end off");
      mode <= 1'h1;
    end
  endtask
  task t_frame;
    begin
      wr(`MSPC_REG_FRAME, 32'h0, 2'h2);
      wr(`MSPC_REG_FRAME, 32'h002, 2'h2);
      wr(`MSPC_REG_FRAME, 32'h052, 2'h2);
      wr(`MSPC_REG_FRAME, 32'h032, 2'h0);
      chk(frame, `MSPC_FRAME_DEFAULT, "frame held");
      mspc_terminal_model_i.send(`MSPC_CH_CR);
      repeat (2) @(posedge clk_i);
      chk(frame, 9'h032, "frame new");
      ctl(32'h004);
      chk(xstop, 1, "extra stop");
      wr(`MSPC_REG_POWERUP, 32'h032, 2'h0);
      ctl(32'h044);
      chk(frame, `MSPC_FRAME_DEFAULT, "default");
      chk(xstop, 0, "extra stop");
      rd(`MSPC_REG_POWERUP, 32'h032, 2'h0);
      ctl(32'h080);
      mspc_terminal_model_i.send(`MSPC_CH_CR);
      repeat (2) @(posedge clk_i);
      chk(frame, 9'h032, "initial");
    end
  endtask
  task t_data;
    begin
      ctl(32'h100);
      chk({dmode, dpass}, 2'h3, "communicate");
      edit(1'h1, 200);
      chk({flow, plim}, {1'h0, 8'h80}, "fill");
      edit(1'h1, 50);
      chk(flow, 1, "flow off");
      edit(1'h0, 60);
      chk(flow, 0, "flow on");
      wr(`MSPC_REG_CIRCUIT, 32'h2, 2'h0);
      chk(dpass, 0, "other circuit");
      wr(`MSPC_REG_CIRCUIT, 32'h0, 2'h0);
      rd(`MSPC_REG_CIRCUIT, 32'h2, 2'h0);
      ctl(32'h000);
      chk(lamp, 0, "lamp idle");
      ctl(32'h008);
      key <= 1'h1;
      repeat (4) @(posedge clk_i);
      chk(lamp, 1, "lamp key");
      key <= 1'h0;
      repeat (4) @(posedge clk_i);
      chk(lamp, 0, "lamp key");
    end
  endtask
  initial
  begin
    #200000;
    n_mismatch++;
    end_sim;
  end
  initial
  begin
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'h1;
    @(posedge clk_i);
    #1;
    chk({frame, dpass}, {`MSPC_FRAME_DEFAULT, 1'h0}, "reset");
    rd(`MSPC_REG_CIRCUIT, 32'h1, 2'h0);
    rd(`MSPC_REG_CMDCHAR, 32'h2b, 2'h0);
    rd(8'h40, 32'h0, 2'h2);
    t_chars;
    t_frame;
    t_data;
    brk_out(32'h020, 245);
    brk_out(32'h021, 159);
    brk_in(215, 1'h1);
    brk_in(50, 1'h0);
    ctl(32'h002);
    brk_in(50, 1'h1);
    end_sim;
  end
endmodule // mspc_serial_port_ctrl_bench

// [verif/mspc_terminal_model.sv]
// Serial terminal at the far side of the port.
// Driven by bench task calls; idle line is high.
`timescale 1ns/1ps
module mspc_terminal_model (
  input wire clk_i,
  output logic [7:0] char_o,
  output logic char_valid_o,
  output logic txd_line_o
);
  initial
  begin
    char_o = 8'h00;
    char_valid_o = 1'h0;
    txd_line_o = 1'h1;
  end
  // One character; data scrambled once released
  task send(input logic [7:0] c);
    begin
      @(posedge clk_i);
      char_o <= c;
      char_valid_o <= 1'h1;
      @(posedge clk_i);
      char_valid_o <= 1'h0;
      char_o <= ~c;
      #1;
    end
  endtask
  task hold_low(input int n);
    begin
      @(posedge clk_i);
      txd_line_o <= 1'h0;
      repeat (n) @(posedge clk_i);
      txd_line_o <= 1'h1;
      #1;
    end
  endtask
endmodule // mspc_terminal_model
